//--- rtl/stt_pkg.sv
package stt_pkg;
    // ===========================================
    // Register map (byte addresses)
    localparam logic [31:0] CTRL_ADDR = 32'he000e010;
    localparam logic [31:0] RELOAD_ADDR = 32'he000e014;
    localparam logic [31:0] CURRENT_ADDR = 32'he000e018;
    // ===========================================
    // Field positions and widths
    localparam int COUNT_W = 24;
    localparam int ENABLE_BIT = 0;
    localparam int WRAP_IE_BIT = 1;
    localparam int CLKSEL_BIT = 2;
    localparam int FLAG_BIT = 16;
    // ===========================================
    // Reset values
    localparam logic [23:0] COUNT_RESET = 24'h000000;
    localparam logic [23:0] RELOAD_RESET = 24'h000000;
    localparam logic CTRL_BIT_RESET = 1'b0;
    // ===========================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ===========================================
    // Register select codes
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h1;
    localparam logic [1:0] SEL_RELOAD = 2'h2;
    localparam logic [1:0] SEL_CURRENT = 2'h3;
endpackage

//--- rtl/stt_sync.sv
`timescale 1ns/100ps
// ===========================================
// Two-stage synchroniser for a pin level
module stt_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output logic pin_sync
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } stt_sync_state_type;

    stt_sync_state_type st;
    stt_sync_state_type next_st;

    // Stage one feeds only stage two
    always_comb begin
        next_st.stage1 = pin_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '1; // Idle-high pin level, so no false edge after reset
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync = st.stage2;
endmodule

//--- rtl/stt_counter.sv
`timescale 1ns/100ps
// ===========================================
// 24-bit decrementing counter with reload and wrap pulse
module stt_counter #(
    parameter int WIDTH = stt_pkg::COUNT_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic clear,
    input wire logic [WIDTH-1:0] reload,
    output logic [WIDTH-1:0] count,
    output logic wrap
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic wrap;
    } stt_counter_state_type;

    stt_counter_state_type st;
    stt_counter_state_type next_st;

    // Clear beats counting and never reports a wrap
    always_comb begin
        next_st = st;
        next_st.wrap = 1'b0;
        if (clear) begin
            next_st.count = '0;
        end else if (run) begin
            if (st.count == '0) begin
                // Reload of zero parks the counter here
                next_st.count = reload;
            end else begin
                next_st.count = st.count - 1'b1;
                // Event only on the step from one to zero
                next_st.wrap = (st.count == {{(WIDTH-1){1'b0}}, 1'b1});
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign wrap = st.wrap;
endmodule

//--- rtl/stt_top.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
// Functional notes
// - 24-bit decrementing counter, cleared by writes
// - Count to zero, reload next edge, continue
// - Reload zero stops counter at next wrap
// - Reaching zero sets wrap flag bit 16
// - Application read of control clears wrap flag
// - Debugger read clears flag only if kind 0
// - Current write clears counter and wrap flag
// - Current write clear never pends tick exception
// - Current read returns live counter value
// - Counter holds while core halted in debug
// - Bit 2 selects core or external clock
// - Bit 1 lets zero pend tick exception
// - Bit 0 enables repeating reload countdown
// - Enable low stops; control resets to zero
// - Byte, halfword, word access; little endian
// - Unprivileged access gives a bus fault
// - Reload N wraps every N+1 clocks
// - Reload in bits 23:0, upper bits read-only
// - Events only on count from one to zero
module stt_top #(
    parameter bit REF_PRESENT = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic debug_read,
    input wire logic debug_master_kind,
    input wire logic core_halted,
    input wire logic ref_clock_in,
    output logic tick_pend
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] awaddr;
        logic awpriv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic enable;
        logic wrap_interrupt_enable;
        logic timer_clock_select;
        logic wrap_flag;
        logic [23:0] reload;
        logic pend;
        logic ref_prev;
    } stt_top_state_type;

    stt_top_state_type st;
    stt_top_state_type next_st;
    logic [23:0] count;
    logic wrap;
    logic ref_sync;
    logic aw_held;
    logic w_held;
    logic wr_commit;
    logic wr_ok;
    logic rd_take;
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;
    logic count_clear;
    logic count_run;
    logic count_tick;

    // ===========================================
    // Address decode, shared by both channels
    function automatic logic [1:0] reg_select(input logic [31:0] addr);
        if (addr[31:2] == stt_pkg::CTRL_ADDR[31:2]) begin
            reg_select = stt_pkg::SEL_CTRL;
        end else if (addr[31:2] == stt_pkg::RELOAD_ADDR[31:2]) begin
            reg_select = stt_pkg::SEL_RELOAD;
        end else if (addr[31:2] == stt_pkg::CURRENT_ADDR[31:2]) begin
            reg_select = stt_pkg::SEL_CURRENT;
        end else begin
            reg_select = stt_pkg::SEL_NONE;
        end
    endfunction

    // Merge enabled byte lanes, lane 0 is the lowest byte
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        lane_merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                lane_merge[8*i +: 8] = new_v[8*i +: 8];
            end
        end
    endfunction

    // ===========================================
    // Reference clock pin; unused while tied off
    stt_sync u_ref_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(ref_clock_in),
        .pin_sync(ref_sync)
    );

    // Edge detect is only honest below core clock over 2.5
    assign count_tick = st.timer_clock_select || !REF_PRESENT ||
                        (ref_sync && !st.ref_prev);
    assign count_run = st.enable && count_tick && !core_halted;

    // ===========================================
    // Handshake bookkeeping
    assign aw_held = !st.awready && !st.bvalid;
    assign w_held = !st.wready && !st.bvalid;
    assign wr_commit = aw_held && w_held;
    assign wr_sel = reg_select(st.awaddr);
    assign wr_ok = wr_commit && st.awpriv && (wr_sel != stt_pkg::SEL_NONE);
    assign rd_take = s_axi_arvalid && st.arready;
    assign rd_sel = reg_select(s_axi_araddr);
    assign count_clear = wr_ok && (wr_sel == stt_pkg::SEL_CURRENT);

    stt_counter #(
        .WIDTH(stt_pkg::COUNT_W)
    ) u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(count_run),
        .clear(count_clear),
        .reload(st.reload),
        .count(count),
        .wrap(wrap)
    );

    // ===========================================
    // Bus slave and register file
    always_comb begin
        logic [31:0] merged;
        merged = '0;
        next_st = st;
        next_st.ref_prev = ref_sync;
        // Address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.awready = 1'b0;
            next_st.awaddr = s_axi_awaddr;
            next_st.awpriv = s_axi_awprot[0];
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wready = 1'b0;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (wr_commit) begin
            next_st.bvalid = 1'b1;
            if (!st.awpriv) begin
                next_st.bresp = stt_pkg::RESP_SLVERR;
            end else if (wr_sel == stt_pkg::SEL_NONE) begin
                next_st.bresp = stt_pkg::RESP_DECERR;
            end else begin
                next_st.bresp = stt_pkg::RESP_OKAY;
            end
        end
        if (wr_ok && wr_sel == stt_pkg::SEL_CTRL && st.wstrb[0]) begin
            // Flag bit is not writable; reserved bits dropped
            next_st.enable = st.wdata[stt_pkg::ENABLE_BIT];
            next_st.wrap_interrupt_enable = st.wdata[stt_pkg::WRAP_IE_BIT];
            next_st.timer_clock_select = st.wdata[stt_pkg::CLKSEL_BIT];
        end
        if (wr_ok && wr_sel == stt_pkg::SEL_RELOAD) begin
            merged = lane_merge({8'h00, st.reload}, st.wdata, st.wstrb);
            next_st.reload = merged[23:0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        // Read answers one cycle after the address is taken
        if (rd_take) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = '0;
            next_st.rresp = stt_pkg::RESP_OKAY;
            if (!s_axi_arprot[0]) begin
                next_st.rresp = stt_pkg::RESP_SLVERR;
            end else begin
                case (rd_sel)
                    stt_pkg::SEL_CTRL: begin
                        next_st.rdata[stt_pkg::FLAG_BIT] = st.wrap_flag;
                        next_st.rdata[stt_pkg::CLKSEL_BIT] = st.timer_clock_select;
                        next_st.rdata[stt_pkg::WRAP_IE_BIT] = st.wrap_interrupt_enable;
                        next_st.rdata[stt_pkg::ENABLE_BIT] = st.enable;
                        if (!debug_read || !debug_master_kind) begin
                            next_st.wrap_flag = 1'b0;
                        end
                    end
                    stt_pkg::SEL_RELOAD: next_st.rdata[23:0] = st.reload;
                    stt_pkg::SEL_CURRENT: next_st.rdata[23:0] = count;
                    default: next_st.rresp = stt_pkg::RESP_DECERR;
                endcase
            end
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (count_clear) begin
            next_st.wrap_flag = 1'b0;
        end
        // A new wrap wins over any clear in the same cycle
        if (wrap) begin
            next_st.wrap_flag = 1'b1;
        end
        // Clearing never makes a wrap, so it never pends
        next_st.pend = wrap && st.wrap_interrupt_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.ref_prev <= 1'b1; // Idle level of the pin, so no false edge
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign tick_pend = st.pend;

    // ===========================================
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_reload;
        count == 24'h000000 && count_run && !count_clear |=> count == $past(st.reload);
    endproperty
    a_reload: assert property (p_reload) else $error("No reload after zero");

    property p_decrement;
        count != 24'h000000 && count_run && !count_clear |=> count == $past(count) - 24'h000001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("Counter did not decrement");

    property p_halt_hold;
        core_halted && !count_clear |=> $stable(count);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("Counted while halted");

    property p_disabled;
        !st.enable && !count_clear |=> $stable(count);
    endproperty
    a_disabled: assert property (p_disabled) else $error("Counted while disabled");

    property p_clear;
        count_clear |=> count == 24'h000000 && !wrap ##1 !tick_pend;
    endproperty
    a_clear: assert property (p_clear) else $error("Clear failed or pended");

    property p_flag_set;
        wrap |=> st.wrap_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Wrap flag not set");

    property p_pend_pulse;
        wrap && st.wrap_interrupt_enable |=> tick_pend ##1 !tick_pend;
    endproperty
    a_pend_pulse: assert property (p_pend_pulse) else $error("Pend not one pulse");

    property p_no_pend;
        !$past(wrap) |-> !tick_pend;
    endproperty
    a_no_pend: assert property (p_no_pend) else $error("Pend without wrap");

    property p_read_clear;
        rd_take && s_axi_arprot[0] && rd_sel == stt_pkg::SEL_CTRL && !debug_read && !wrap
            |=> !st.wrap_flag && s_axi_rdata[stt_pkg::FLAG_BIT] == $past(st.wrap_flag);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("Read did not clear flag");

    property p_debug_keep;
        rd_take && s_axi_arprot[0] && debug_read && debug_master_kind && !count_clear
            |=> st.wrap_flag == $past(st.wrap_flag) || $past(wrap);
    endproperty
    a_debug_keep: assert property (p_debug_keep) else $error("Debugger read changed flag");

    property p_unpriv;
        rd_take && !s_axi_arprot[0] |=> s_axi_rvalid && s_axi_rresp == stt_pkg::RESP_SLVERR;
    endproperty
    a_unpriv: assert property (p_unpriv) else $error("Unprivileged read not faulted");

    c_wrap_pend: cover property (wrap && st.wrap_interrupt_enable ##1 tick_pend);
    c_cur_clear: cover property (count_clear && count != 24'h000000);
    c_flag_read: cover property (rd_take && rd_sel == stt_pkg::SEL_CTRL && st.wrap_flag);
endmodule

//--- bench/system_tick_timer_test.sv
`timescale 1ns/100ps
// ===========================================
// Self-checking bench for the tick timer, driven over its register bus
module system_tick_timer_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic debug_read = 1'b0, debug_master_kind = 1'b0, core_halted = 1'b0, ref_clock_in = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tick_pend;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int fail_count = 0;
    int num_checks = 0;
    int pend_count = 0;
    logic [31:0] q;
    logic [1:0] r;
    logic [31:0] c;
    int p;

    // ===========================================
    // Clock, pend counter and design
    always #10 aclk = ~aclk;

    // A stuck pend level counts every cycle, so the period checks catch it
    always @(posedge aclk) begin
        if (tick_pend === 1'b1) begin
            pend_count <= pend_count + 1;
        end
    end

    stt_top #(.REF_PRESENT(1'b0)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .debug_read(debug_read), .debug_master_kind(debug_master_kind),
        .core_halted(core_halted), .ref_clock_in(ref_clock_in), .tick_pend(tick_pend)
    );

    // ===========================================
    // Checking and closing
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ===========================================
    // Bus master: handshakes judged at the falling edge, where registered readies are settled
    task automatic bus(input logic w_en, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [2:0] pr, input logic dbg);
        logic ta, tw, tr, done;
        done = 1'b0;
        @(posedge aclk);
        if (w_en) begin
            s_axi_awaddr <= a;
            s_axi_awprot <= pr;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arprot <= pr;
            s_axi_arvalid <= 1'b1;
            debug_read <= dbg;
            s_axi_rready <= 1'b1;
        end
        while (done !== 1'b1) begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            done = w_en ? s_axi_bvalid : s_axi_rvalid;
            q = w_en ? 32'h0 : s_axi_rdata;
            r = w_en ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (done === 1'b1) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                debug_read <= 1'b0;
            end
        end
        // Readies must be back up once the answer has been taken
        @(negedge aclk);
        chk("ready_after_answer", 32'h1, {31'h0, w_en ? (s_axi_awready & s_axi_wready) : s_axi_arready});
        @(posedge aclk);
    endtask

    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf, 3'h1, 1'b0);
    endtask

    task automatic rreg(input logic [31:0] a);
        bus(1'b0, a, 32'h0, 4'h0, 3'h1, 1'b0);
    endtask

    // Let the counter run a while under the given control value, then stop it
    task automatic run_stop(input logic [31:0] ctrl);
        wreg(stt_pkg::CTRL_ADDR, ctrl);
        repeat (20) @(posedge aclk);
        wreg(stt_pkg::CTRL_ADDR, 32'h0);
    endtask

    // ===========================================
    // Scenarios
    task automatic t_reset();
        rreg(stt_pkg::CTRL_ADDR);
        chk("ctrl_reset", 32'h0, q);
        rreg(stt_pkg::RELOAD_ADDR);
        chk("reload_reset", 32'h0, q);
        rreg(stt_pkg::CURRENT_ADDR);
        chk("current_reset", 32'h0, q);
    endtask

    task automatic t_regs();
        wreg(stt_pkg::RELOAD_ADDR, 32'hff000005);
        rreg(stt_pkg::RELOAD_ADDR);
        chk("reload_field", 32'h00000005, q);
        bus(1'b1, stt_pkg::RELOAD_ADDR, 32'h00ab0000, 4'h4, 3'h1, 1'b0);
        rreg(stt_pkg::RELOAD_ADDR);
        chk("reload_lane2", 32'h00ab0005, q);
        wreg(stt_pkg::RELOAD_ADDR, 32'h5);
        // Reserved control bits are left at zero by software
        wreg(stt_pkg::CTRL_ADDR, 32'h6);
        rreg(stt_pkg::CTRL_ADDR);
        chk("ctrl_fields", 32'h6, q);
        wreg(stt_pkg::CTRL_ADDR, 32'h0);
        rreg(stt_pkg::CURRENT_ADDR);
        chk("idle_count", 32'h0, q);
    endtask

    task automatic t_access();
        bus(1'b1, stt_pkg::CTRL_ADDR, 32'h1, 4'hf, 3'h0, 1'b0);
        chk("unpriv_bresp", {30'h0, stt_pkg::RESP_SLVERR}, {30'h0, r});
        rreg(stt_pkg::CTRL_ADDR);
        chk("unpriv_no_effect", 32'h0, q);
        bus(1'b0, stt_pkg::CTRL_ADDR, 32'h0, 4'h0, 3'h0, 1'b0);
        chk("unpriv_rresp", {30'h0, stt_pkg::RESP_SLVERR}, {30'h0, r});
        rreg(32'he000e01c);
        chk("unmapped_rresp", {30'h0, stt_pkg::RESP_DECERR}, {30'h0, r});
        chk("unmapped_rdata", 32'h0, q);
    endtask

    // Reload 5 must give a one-cycle pend every 6 clocks
    task automatic t_period();
        int n;
        wreg(stt_pkg::CTRL_ADDR, 32'h7);
        n = 0;
        while (tick_pend !== 1'b1 && n < 50) begin
            @(negedge aclk);
            n++;
        end
        @(negedge aclk);
        chk("pend_width", 32'h0, {31'h0, tick_pend});
        n = 1;
        while (tick_pend !== 1'b1 && n < 50) begin
            @(negedge aclk);
            n++;
        end
        chk("wrap_period", 32'd6, n);
        wreg(stt_pkg::CTRL_ADDR, 32'h5);
        repeat (2) @(posedge aclk);
        p = pend_count;
        repeat (30) @(posedge aclk);
        chk("pend_masked", p, pend_count);
        wreg(stt_pkg::CTRL_ADDR, 32'h0);
    endtask

    task automatic t_flag();
        debug_master_kind <= 1'b1;
        bus(1'b0, stt_pkg::CTRL_ADDR, 32'h0, 4'h0, 3'h1, 1'b1);
        chk("dbg_keep_read", 32'h10000, q);
        bus(1'b0, stt_pkg::CTRL_ADDR, 32'h0, 4'h0, 3'h1, 1'b1);
        chk("dbg_keep_after", 32'h10000, q);
        rreg(stt_pkg::CTRL_ADDR);
        chk("flag_set", 32'h10000, q);
        rreg(stt_pkg::CTRL_ADDR);
        chk("flag_read_clear", 32'h0, q);
        run_stop(32'h1);
        debug_master_kind <= 1'b0;
        bus(1'b0, stt_pkg::CTRL_ADDR, 32'h0, 4'h0, 3'h1, 1'b1);
        chk("dbg_clear_read", 32'h10000, q);
        rreg(stt_pkg::CTRL_ADDR);
        chk("dbg_cleared", 32'h0, q);
        rreg(stt_pkg::CURRENT_ADDR);
        c = q;
        rreg(stt_pkg::CURRENT_ADDR);
        chk("stopped_count", c, q);
    endtask

    // Clearing write with no strobes, interrupt enabled but counter stopped
    task automatic t_clear();
        run_stop(32'h7);
        wreg(stt_pkg::CTRL_ADDR, 32'h2);
        p = pend_count;
        bus(1'b1, stt_pkg::CURRENT_ADDR, 32'h12345678, 4'h0, 3'h1, 1'b0);
        rreg(stt_pkg::CURRENT_ADDR);
        chk("current_cleared", 32'h0, q);
        rreg(stt_pkg::CTRL_ADDR);
        chk("flag_write_clear", 32'h2, q);
        chk("no_pend_on_clear", p, pend_count);
    endtask

    // Halt freezes the count; reload zero then lets it finish one last wrap only
    task automatic t_halt();
        wreg(stt_pkg::RELOAD_ADDR, 32'h5);
        wreg(stt_pkg::CTRL_ADDR, 32'h7);
        repeat (10) @(posedge aclk);
        core_halted <= 1'b1;
        repeat (3) @(posedge aclk);
        p = pend_count;
        rreg(stt_pkg::CURRENT_ADDR);
        c = q;
        chk("current_range", 32'h1, {31'h0, c <= 32'h5});
        wreg(stt_pkg::RELOAD_ADDR, 32'h0);
        rreg(stt_pkg::CURRENT_ADDR);
        chk("halted_hold", c, q);
        repeat (20) @(posedge aclk);
        chk("halted_no_pend", p, pend_count);
        core_halted <= 1'b0;
        repeat (20) @(posedge aclk);
        chk("last_wrap", p + int'(c != 32'h0), pend_count);
        rreg(stt_pkg::CURRENT_ADDR);
        chk("parked_at_zero", 32'h0, q);
        wreg(stt_pkg::CTRL_ADDR, 32'h0);
    endtask

    // ===========================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_regs();
        t_access();
        t_period();
        t_flag();
        t_clear();
        t_halt();
        wrap_up();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("mismatch watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule
